/* File: verilog/mid_pkg.sv */
// Purpose: Shared constants and code types for the module identity and capability table
// Assumes: Management registers are 16 bits wide with content in the low byte
// Notes:   Offsets are management addresses, one byte of content per address
`default_nettype none
package mid_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;

  // Register offsets
  localparam logic [15:0] MEDIA_PROPERTIES_ADDR       = 16'h800a;
  localparam logic [15:0] MAX_NETWORK_LANE_RATE_ADDR  = 16'h800b;
  localparam logic [15:0] MAX_HOST_LANE_RATE_ADDR     = 16'h800c;
  localparam logic [15:0] MAX_SINGLE_MODE_REACH_ADDR  = 16'h800d;
  localparam logic [15:0] MAX_MULTIMODE_REACH_ADDR    = 16'h800e;
  localparam logic [15:0] MAX_COPPER_REACH_ADDR       = 16'h800f;
  localparam logic [15:0] TX_FIBER_COUNT_ADDR         = 16'h8010;
  localparam logic [15:0] WAVELENGTHS_PER_FIBER_ADDR  = 16'h8011;
  localparam logic [15:0] MIN_WAVELENGTH_ADDR         = 16'h8012;
  localparam logic [15:0] MAX_WAVELENGTH_ADDR         = 16'h8014;
  localparam logic [15:0] LANE_OPTICAL_WIDTH_ADDR     = 16'h8016;
  localparam logic [15:0] LASER_AND_MODULATOR_ADDR    = 16'h8018;
  localparam logic [15:0] TX_DETECTOR_FEATURES_ADDR   = 16'h8019;
  localparam logic [15:0] LINE_SIGNAL_CODING_ADDR     = 16'h801a;
  localparam logic [15:0] MAX_OUTPUT_POWER_ADDR       = 16'h801b;
  localparam logic [15:0] MAX_INPUT_POWER_ADDR        = 16'h801c;
  localparam logic [15:0] MAX_POWER_DRAW_ADDR         = 16'h801d;
  localparam logic [15:0] MAX_LOW_POWER_DRAW_ADDR     = 16'h801e;
  localparam logic [15:0] CASE_TEMP_UPPER_ADDR        = 16'h801f;
  localparam logic [15:0] CASE_TEMP_LOWER_ADDR        = 16'h8020;
  localparam logic [15:0] MAKER_NAME_TEXT_ADDR        = 16'h8021;
  localparam logic [15:0] MAKER_COMPANY_ID_ADDR       = 16'h8031;
  localparam logic [15:0] MAKER_PART_TEXT_ADDR        = 16'h8034;
  localparam logic [15:0] MAKER_SERIAL_TEXT_ADDR      = 16'h8044;
  localparam logic [15:0] MANUFACTURE_DATE_ADDR       = 16'h8054;
  localparam logic [15:0] PRODUCTION_LOT_ADDR         = 16'h805c;
  localparam logic [15:0] EQUIPMENT_CATALOG_ADDR      = 16'h805e;
  localparam logic [15:0] HW_SPEC_REVISION_ADDR       = 16'h8068;
  localparam logic [15:0] MGMT_SPEC_REVISION_ADDR     = 16'h8069;
  localparam logic [15:0] MODULE_HW_VERSION_ADDR      = 16'h806a;
  localparam logic [15:0] MODULE_FW_VERSION_ADDR      = 16'h806c;
  localparam logic [15:0] MONITOR_MEASURE_TYPE_ADDR   = 16'h806e;
  localparam logic [15:0] MODULE_MONITOR_CAPS_ADDR    = 16'h806f;
  localparam logic [15:0] LANE_MONITOR_CAPS_ADDR      = 16'h8070;
  localparam logic [15:0] OPTIONAL_FEATURES_1_ADDR    = 16'h8071;
  localparam logic [15:0] POWER_UP_TIME_LIMIT_ADDR    = 16'h8072;
  localparam logic [15:0] TX_ON_TIME_LIMIT_ADDR       = 16'h8073;
  localparam logic [15:0] HOST_INTERFACE_TYPE_ADDR    = 16'h8074;
  localparam logic [15:0] TOP_SURFACE_TYPE_ADDR       = 16'h8075;
  localparam logic [15:0] TX_OFF_TIME_LIMIT_ADDR      = 16'h8076;
  localparam logic [15:0] POWER_DOWN_TIME_LIMIT_ADDR  = 16'h8077;
  localparam logic [15:0] OPTIONAL_FEATURES_2_ADDR    = 16'h8078;
  localparam logic [15:0] TABLE_FIRST_ADDR            = MEDIA_PROPERTIES_ADDR;
  localparam logic [15:0] TABLE_LAST_ADDR             = OPTIONAL_FEATURES_2_ADDR;

  // Field lengths in bytes
  localparam int unsigned TEXT_LEN       = 16;
  localparam int unsigned COMPANY_ID_LEN = 3;
  localparam int unsigned DATE_LEN       = 8;
  localparam int unsigned LOT_LEN        = 2;
  localparam int unsigned CATALOG_LEN    = 10;

  // Unit conversions and limits
  localparam int unsigned FIBER_COUNT_WRAP = 16;
  localparam int unsigned MS_PER_SECOND    = 1000;
  localparam int unsigned US_PER_MS        = 1000;
  localparam int unsigned BYTE_MAX         = 255;

  typedef enum logic [1:0] {
    MID_MEDIA_SMF    = 2'h0,
    MID_MEDIA_MMF    = 2'h1,
    MID_MEDIA_COPPER = 2'h3
  } mid_media_type;

  typedef enum logic [3:0] {
    MID_LASER_VCSEL  = 4'h0,
    MID_LASER_FP     = 4'h1,
    MID_LASER_DFB    = 4'h2,
    MID_LASER_DBR    = 4'h3,
    MID_LASER_COPPER = 4'h4
  } mid_laser_type;

  typedef enum logic [3:0] {
    MID_MOD_DIRECT     = 4'h0,
    MID_MOD_ELECTROABS = 4'h1,
    MID_MOD_INP_MZ     = 4'h2,
    MID_MOD_LN_MZ      = 4'h3,
    MID_MOD_COPPER     = 4'h4
  } mid_modulator_type;

  typedef enum logic [1:0] {
    MID_DET_UNDEFINED = 2'h0,
    MID_DET_PIN       = 2'h1,
    MID_DET_APD       = 2'h2,
    MID_DET_AMP_PIN   = 2'h3
  } mid_detector_type;

  typedef enum logic [1:0] {
    MID_LINE_UNDEFINED = 2'h0,
    MID_LINE_NRZ       = 2'h1,
    MID_LINE_RZ        = 2'h2
  } mid_line_mod_type;

  typedef enum logic [3:0] {
    MID_CODE_NON_PSK = 4'h0,
    MID_CODE_ODB     = 4'h1,
    MID_CODE_DPSK    = 4'h2,
    MID_CODE_QPSK    = 4'h3,
    MID_CODE_DQPSK   = 4'h4,
    MID_CODE_QAM16   = 4'hb,
    MID_CODE_QAM64   = 4'hc,
    MID_CODE_QAM256  = 4'hd
  } mid_coding_type;

  typedef enum logic [7:0] {
    MID_HOST_UNSPECIFIED = 8'h00,
    MID_HOST_CAUI        = 8'h01,
    MID_HOST_XLAUI       = 8'h02,
    MID_HOST_SFI52       = 8'h03
  } mid_host_iface_type;

endpackage
`default_nettype wire

/* File: verilog/mid_capability_rom.sv */
// Purpose: Read-only identity and capability table reached over management registers
// Assumes: Management frame logic presents one register access per strobe
// Notes:   Each register reads its content byte in bits 7:0, upper bits zero
`timescale 1ns/1ns
`default_nettype none
module mid_capability_rom
  import mid_pkg::*;
#(
  parameter mid_media_type      MEDIA_TYPE        = MID_MEDIA_SMF,
  parameter logic               BIDIRECTIONAL     = 1'b0,
  parameter logic               OPTICAL_MUX       = 1'b1,
  parameter int unsigned        ACTIVE_FIBERS     = 1,
  parameter logic [7:0]         NETWORK_RATE      = 8'h00,
  parameter logic [7:0]         HOST_RATE         = 8'h00,
  parameter logic [7:0]         SM_REACH          = 8'h00,
  parameter logic [7:0]         MM_REACH          = 8'h00,
  parameter logic [7:0]         COPPER_REACH      = 8'h00,
  parameter logic [4:0]         TX_FIBERS         = 5'h00,
  parameter logic [4:0]         WAVES_PER_FIBER   = 5'h00,
  parameter logic [15:0]        MIN_WAVELENGTH    = 16'h0000,
  parameter logic [15:0]        MAX_WAVELENGTH    = 16'h0000,
  parameter logic [15:0]        OPTICAL_WIDTH     = 16'h0000,
  parameter mid_laser_type      LASER_TYPE        = MID_LASER_DFB,
  parameter mid_modulator_type  MODULATOR_TYPE    = MID_MOD_DIRECT,
  parameter logic [3:0]         TX_FEATURE_FLAGS  = 4'h0,
  parameter mid_detector_type   DETECTOR_TYPE     = MID_DET_PIN,
  parameter mid_line_mod_type   LINE_MOD          = MID_LINE_NRZ,
  parameter mid_coding_type     SIGNAL_CODING     = MID_CODE_NON_PSK,
  parameter logic [7:0]         OUTPUT_POWER      = 8'h00,
  parameter logic [7:0]         INPUT_POWER       = 8'h00,
  parameter logic [7:0]         POWER_DRAW        = 8'h00,
  parameter logic [7:0]         LOW_POWER_DRAW    = 8'h00,
  parameter logic signed [7:0]  CASE_TEMP_MAX     = 8'sh46,
  parameter logic signed [7:0]  CASE_TEMP_MIN     = 8'sh00,
  parameter logic [127:0]       MAKER_NAME        = "GENERIC MAKER   ",
  parameter logic [23:0]        COMPANY_ID        = 24'h000000, // Arbitrary value
  parameter logic [127:0]       PART_TEXT         = "PART0000        ",
  parameter logic [127:0]       SERIAL_TEXT       = "SERIAL0000      ",
  parameter logic [63:0]        DATE_TEXT         = "20000101",
  parameter logic [15:0]        LOT_TEXT          = "00",
  parameter logic [79:0]        CATALOG_TEXT      = "0000000000",
  parameter logic [7:0]         HW_SPEC_REV_X10   = 8'h0a,
  parameter logic [7:0]         MGMT_SPEC_REV_X10 = 8'h0a,
  parameter logic [7:0]         HW_VER_MAJOR      = 8'h01,
  parameter logic [7:0]         HW_VER_MINOR      = 8'h00,
  parameter logic [7:0]         FW_VER_MAJOR      = 8'h01,
  parameter logic [7:0]         FW_VER_MINOR      = 8'h00,
  parameter logic               RX_AVG_POWER      = 1'b1,
  parameter logic               TX_AVG_POWER      = 1'b1,
  parameter logic [7:0]         MODULE_MON_CAPS   = 8'h00,
  parameter logic [3:0]         LANE_MON_CAPS     = 4'h0,
  parameter logic [7:0]         OPT_FEATURES_1    = 8'h00,
  parameter int unsigned        POWER_UP_MS       = 1,
  parameter int unsigned        TX_ON_MS          = 1,
  parameter mid_host_iface_type HOST_IFACE        = MID_HOST_CAUI,
  parameter logic               INTEGRATED_SINK   = 1'b0,
  parameter int unsigned        TX_OFF_US         = 1,
  parameter int unsigned        POWER_DOWN_MS     = 1,
  parameter logic               DECISION_ADJUST   = 1'b0
) (
  input  wire logic              core_clk_i,
  input  wire logic              arst_n_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic              reg_rd_i,
  input  wire logic              reg_wr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  output logic                   reg_ack_o,
  output logic                   reg_hit_o,
  output logic      [7:0]        table_sum_o
);

  // Round a time up to whole units, at least one, saturating
  function automatic logic [7:0] to_units(input int unsigned t, input int unsigned unit);
    int unsigned q;
    q = (t + unit - 1) / unit;
    if (q < 1) begin
      q = 1;
    end
    if (q > BYTE_MAX) begin
      q = BYTE_MAX;
    end
    return q[7:0];
  endfunction

  // Pick the n-th byte of a text field, first character most significant
  function automatic logic [7:0] text_byte(input logic [127:0] txt, input int unsigned len,
                                           input int unsigned idx);
    return txt[8*(len-1-idx) +: 8];
  endfunction

  localparam logic [3:0] FIBER_CODE =
    (ACTIVE_FIBERS == FIBER_COUNT_WRAP) ? 4'h0 : 4'(ACTIVE_FIBERS);
  localparam logic [7:0] MEDIA_BYTE =
    {MEDIA_TYPE, BIDIRECTIONAL, OPTICAL_MUX, FIBER_CODE};
  localparam logic [7:0] TECH1_BYTE = {LASER_TYPE, MODULATOR_TYPE};
  localparam logic [7:0] TECH2_BYTE = {TX_FEATURE_FLAGS, DETECTOR_TYPE, 2'h0};
  localparam logic [7:0] CODE_BYTE  = {LINE_MOD, SIGNAL_CODING, 2'h0};
  localparam logic [7:0] MEAS_BYTE  = {4'h0, RX_AVG_POWER, TX_AVG_POWER, 2'h0};
  localparam logic [7:0] LANE_CAPS_BYTE = {4'h0, LANE_MON_CAPS};
  localparam logic [7:0] MOD_CAPS_BYTE  = MODULE_MON_CAPS & 8'hf7;
  localparam logic [7:0] SINK_BYTE  = {7'h00, INTEGRATED_SINK};
  localparam logic [7:0] OPT2_BYTE  = {3'h0, DECISION_ADJUST, 4'h0};
  localparam logic [7:0] POWER_UP_BYTE   = to_units(POWER_UP_MS, MS_PER_SECOND);
  localparam logic [7:0] TX_ON_BYTE      = to_units(TX_ON_MS, MS_PER_SECOND);
  localparam logic [7:0] TX_OFF_BYTE     = to_units(TX_OFF_US, US_PER_MS);
  localparam logic [7:0] POWER_DOWN_BYTE = to_units(POWER_DOWN_MS, MS_PER_SECOND);

  // Content byte at a management address, zero outside the table
  function automatic logic [7:0] rom_byte(input logic [15:0] a);
    int unsigned i;
    i = 0;
    if (a >= MAKER_NAME_TEXT_ADDR && a < MAKER_COMPANY_ID_ADDR) begin
      i = int'(a - MAKER_NAME_TEXT_ADDR);
      return text_byte(MAKER_NAME, TEXT_LEN, i);
    end
    if (a >= MAKER_COMPANY_ID_ADDR && a < MAKER_PART_TEXT_ADDR) begin
      i = int'(a - MAKER_COMPANY_ID_ADDR);
      return text_byte({104'h0, COMPANY_ID}, COMPANY_ID_LEN, i);
    end
    if (a >= MAKER_PART_TEXT_ADDR && a < MAKER_SERIAL_TEXT_ADDR) begin
      i = int'(a - MAKER_PART_TEXT_ADDR);
      return text_byte(PART_TEXT, TEXT_LEN, i);
    end
    if (a >= MAKER_SERIAL_TEXT_ADDR && a < MANUFACTURE_DATE_ADDR) begin
      i = int'(a - MAKER_SERIAL_TEXT_ADDR);
      return text_byte(SERIAL_TEXT, TEXT_LEN, i);
    end
    if (a >= MANUFACTURE_DATE_ADDR && a < PRODUCTION_LOT_ADDR) begin
      i = int'(a - MANUFACTURE_DATE_ADDR);
      return text_byte({64'h0, DATE_TEXT}, DATE_LEN, i);
    end
    if (a >= PRODUCTION_LOT_ADDR && a < EQUIPMENT_CATALOG_ADDR) begin
      i = int'(a - PRODUCTION_LOT_ADDR);
      return text_byte({112'h0, LOT_TEXT}, LOT_LEN, i);
    end
    if (a >= EQUIPMENT_CATALOG_ADDR && a < HW_SPEC_REVISION_ADDR) begin
      i = int'(a - EQUIPMENT_CATALOG_ADDR);
      return text_byte({48'h0, CATALOG_TEXT}, CATALOG_LEN, i);
    end
    case (a)
      MEDIA_PROPERTIES_ADDR:           return MEDIA_BYTE;
      MAX_NETWORK_LANE_RATE_ADDR:      return NETWORK_RATE;
      MAX_HOST_LANE_RATE_ADDR:         return HOST_RATE;
      MAX_SINGLE_MODE_REACH_ADDR:      return SM_REACH;
      MAX_MULTIMODE_REACH_ADDR:        return MM_REACH;
      MAX_COPPER_REACH_ADDR:           return COPPER_REACH;
      TX_FIBER_COUNT_ADDR:             return {3'h0, TX_FIBERS};
      WAVELENGTHS_PER_FIBER_ADDR:      return {3'h0, WAVES_PER_FIBER};
      MIN_WAVELENGTH_ADDR:             return MIN_WAVELENGTH[15:8];
      MIN_WAVELENGTH_ADDR + 16'h1:     return MIN_WAVELENGTH[7:0];
      MAX_WAVELENGTH_ADDR:             return MAX_WAVELENGTH[15:8];
      MAX_WAVELENGTH_ADDR + 16'h1:     return MAX_WAVELENGTH[7:0];
      LANE_OPTICAL_WIDTH_ADDR:         return OPTICAL_WIDTH[15:8];
      LANE_OPTICAL_WIDTH_ADDR + 16'h1: return OPTICAL_WIDTH[7:0];
      LASER_AND_MODULATOR_ADDR:        return TECH1_BYTE;
      TX_DETECTOR_FEATURES_ADDR:       return TECH2_BYTE;
      LINE_SIGNAL_CODING_ADDR:         return CODE_BYTE;
      MAX_OUTPUT_POWER_ADDR:           return OUTPUT_POWER;
      MAX_INPUT_POWER_ADDR:            return INPUT_POWER;
      MAX_POWER_DRAW_ADDR:             return POWER_DRAW;
      MAX_LOW_POWER_DRAW_ADDR:         return LOW_POWER_DRAW;
      CASE_TEMP_UPPER_ADDR:            return CASE_TEMP_MAX;
      CASE_TEMP_LOWER_ADDR:            return CASE_TEMP_MIN;
      HW_SPEC_REVISION_ADDR:           return HW_SPEC_REV_X10;
      MGMT_SPEC_REVISION_ADDR:         return MGMT_SPEC_REV_X10;
      MODULE_HW_VERSION_ADDR:          return HW_VER_MAJOR;
      MODULE_HW_VERSION_ADDR + 16'h1:  return HW_VER_MINOR;
      MODULE_FW_VERSION_ADDR:          return FW_VER_MAJOR;
      MODULE_FW_VERSION_ADDR + 16'h1:  return FW_VER_MINOR;
      MONITOR_MEASURE_TYPE_ADDR:       return MEAS_BYTE;
      MODULE_MONITOR_CAPS_ADDR:        return MOD_CAPS_BYTE;
      LANE_MONITOR_CAPS_ADDR:          return LANE_CAPS_BYTE;
      OPTIONAL_FEATURES_1_ADDR:        return OPT_FEATURES_1;
      POWER_UP_TIME_LIMIT_ADDR:        return POWER_UP_BYTE;
      TX_ON_TIME_LIMIT_ADDR:           return TX_ON_BYTE;
      HOST_INTERFACE_TYPE_ADDR:        return HOST_IFACE;
      TOP_SURFACE_TYPE_ADDR:           return SINK_BYTE;
      TX_OFF_TIME_LIMIT_ADDR:          return TX_OFF_BYTE;
      POWER_DOWN_TIME_LIMIT_ADDR:      return POWER_DOWN_BYTE;
      OPTIONAL_FEATURES_2_ADDR:        return OPT2_BYTE;
      default:                         return 8'h00;
    endcase
  endfunction

  function automatic logic in_table(input logic [15:0] a);
    return (a >= TABLE_FIRST_ADDR) && (a <= TABLE_LAST_ADDR);
  endfunction

  logic [7:0] next_table_sum;

  // Sum of every table byte, reserved bits already zero
  always_comb begin
    next_table_sum = 8'h00;
    for (int unsigned k = 32'(TABLE_FIRST_ADDR); k <= 32'(TABLE_LAST_ADDR); k++) begin
      next_table_sum = 8'(next_table_sum + rom_byte(16'(k)));
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      table_sum_o <= 8'h00;
    end else begin
      table_sum_o <= next_table_sum;
    end
  end

  // Read answers; writes are acknowledged and change nothing
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= {8'h00, rom_byte(reg_addr_i)};
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_ack_o <= 1'b0;
      reg_hit_o <= 1'b0;
    end else begin
      reg_ack_o <= reg_rd_i | reg_wr_i;
      reg_hit_o <= (reg_rd_i | reg_wr_i) & in_table(reg_addr_i);
    end
  end

  logic unused_wdata;
  assign unused_wdata = ^reg_wdata_i;

endmodule // mid_capability_rom
`default_nettype wire

/* File: verif/mid_capability_rom_properties.sv */
// Purpose: Port-level properties of the identity and capability table
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to every instance of the table
`timescale 1ns/1ns
`default_nettype none
module mid_capability_rom_chk
  import mid_pkg::*;
(
  input wire logic              core_clk_i,
  input wire logic              arst_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic              reg_rd_i,
  input wire logic              reg_wr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic              reg_ack_o,
  input wire logic              reg_hit_o,
  input wire logic [7:0]        table_sum_o
);
  logic in_tab;
  assign in_tab = (reg_addr_i >= TABLE_FIRST_ADDR) && (reg_addr_i <= TABLE_LAST_ADDR);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_ack; (reg_rd_i || reg_wr_i) |=> reg_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("strobe not answered");
  property p_ack_cause; reg_ack_o |-> $past(reg_rd_i || reg_wr_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("answer without strobe");
  property p_pulse; (reg_rd_i || reg_wr_i) ##1 !(reg_rd_i || reg_wr_i) |=> !reg_ack_o && !reg_hit_o; endproperty
  a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
  property p_hit_in; reg_rd_i && in_tab |=> reg_hit_o; endproperty
  a_hit_in: assert property (p_hit_in) else $error("table read without hit");
  property p_out_zero; reg_rd_i && !in_tab |=> !reg_hit_o && (reg_rdata_o == 16'h0000); endproperty
  a_out_zero: assert property (p_out_zero) else $error("unmapped read not zero");
  property p_upper; reg_ack_o |-> (reg_rdata_o[15:8] == 8'h00); endproperty
  a_upper: assert property (p_upper) else $error("upper data byte not zero");
  property p_wr_keep; reg_wr_i && !reg_rd_i |=> reg_ack_o && $stable(reg_rdata_o); endproperty
  a_wr_keep: assert property (p_wr_keep) else $error("write changed read data");
  property p_sum; (table_sum_o != 8'h00) |=> $stable(table_sum_o); endproperty
  a_sum: assert property (p_sum) else $error("table sum changed");
  property p_rsvd_type;
    reg_rd_i && (reg_addr_i == MONITOR_MEASURE_TYPE_ADDR) |=> (reg_rdata_o[7:4] == 4'h0) && (reg_rdata_o[1:0] == 2'h0);
  endproperty
  a_rsvd_type: assert property (p_rsvd_type) else $error("measure type reserved bits set");
  property p_rsvd_opt2;
    reg_rd_i && (reg_addr_i == OPTIONAL_FEATURES_2_ADDR) |=> (reg_rdata_o[7:5] == 3'h0) && (reg_rdata_o[3:0] == 4'h0);
  endproperty
  a_rsvd_opt2: assert property (p_rsvd_opt2) else $error("option byte reserved bits set");
endmodule // mid_capability_rom_chk
bind mid_capability_rom mid_capability_rom_chk u_chk (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
  .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .reg_hit_o(reg_hit_o), .table_sum_o(table_sum_o));
`default_nettype wire

/* File: verif/mid_host_model.sv */
// Purpose: Management controller model on the register port
// Assumes: Strobes one cycle each, answer one cycle later
// Notes:   Released address and data show the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module mid_host_model
  import mid_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic [DATA_W-1:0] reg_rdata_i,
  input  wire logic              reg_ack_i,
  input  wire logic              reg_hit_i,
  output logic      [ADDR_W-1:0] reg_addr_o,
  output logic                   reg_rd_o,
  output logic                   reg_wr_o,
  output logic      [DATA_W-1:0] reg_wdata_o
);
  logic [DATA_W-1:0] rq[$];
  logic              hq[$];
  initial begin
    reg_addr_o = '0;
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_wdata_o = '0;
  end
  task automatic strobe(input logic [ADDR_W-1:0] a, input logic r, input logic w, input logic [DATA_W-1:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= r;
    reg_wr_o <= w;
    reg_wdata_o <= d;
  endtask
  task automatic idle();
    @(posedge core_clk_i);
    reg_rd_o <= 1'b0;
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~reg_addr_o;
    reg_wdata_o <= ~reg_wdata_o;
  endtask
  // Collects each answer once settled
  always @(posedge core_clk_i) begin
    #1;
    if (reg_ack_i === 1'b1) begin
      rq.push_back(reg_rdata_i);
      hq.push_back(reg_hit_i);
    end
  end
endmodule // mid_host_model
`default_nettype wire

/* File: verif/tb_mid_capability_rom.sv */
// Purpose: Self-checking bench for the identity and capability table
// Assumes: Host model drives the register port
// Notes:   Expected bytes built from field encodings below
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; $display("Error at %0t got %h exp %h", $time, g, e); end end
module tb_mid_capability_rom
  import mid_pkg::*;
;
  logic              core_clk = 1'b0;
  logic              arst_n = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic              rd, wr, ack, hit;
  logic [DATA_W-1:0] wdata, rdata, last;
  logic [7:0]        sum;
  logic [7:0]        rom [16'h800a:16'h8078];
  logic [DATA_W-1:0] eq[$];
  int                hx[$];
  int                errors = 0;
  int                n_tests = 0;
  int                seed, tsum;
  logic [ADDR_W-1:0] addr_w;
  localparam logic [7:0]  T_NET = 8'hc8, T_SM = 8'h0a, T_DRAW = 8'h44, T_TMIN = 8'hd8;
  localparam logic [7:0]  T_HWMIN = 8'h07, T_FWMAJ = 8'h03, T_MONC = 8'hff, T_OPT1 = 8'h5a;
  localparam logic [4:0]  T_TXF = 5'h1f, T_WPF = 5'h13;
  localparam logic [15:0] T_WMIN = 16'hbeef, T_WMAX = 16'h1234, T_OWID = 16'h0a5c;
  localparam logic [3:0]  T_FEAT = 4'ha, T_LCAP = 4'hb;
  localparam logic [23:0] T_CID = 24'habcdef;
  localparam logic        T_ON = 1'b1, T_OFF = 1'b0;
  localparam int          T_FIB = 16, T_PUP = 1001, T_PDN = 2000, T_TOFF = 999;
  always #2 core_clk = ~core_clk;
  mid_capability_rom #(.MEDIA_TYPE(MID_MEDIA_COPPER), .BIDIRECTIONAL(T_ON), .OPTICAL_MUX(T_OFF),
    .ACTIVE_FIBERS(T_FIB), .NETWORK_RATE(T_NET), .SM_REACH(T_SM), .TX_FIBERS(T_TXF), .WAVES_PER_FIBER(T_WPF),
    .MIN_WAVELENGTH(T_WMIN), .MAX_WAVELENGTH(T_WMAX), .OPTICAL_WIDTH(T_OWID), .LASER_TYPE(MID_LASER_COPPER),
    .MODULATOR_TYPE(MID_MOD_INP_MZ), .TX_FEATURE_FLAGS(T_FEAT), .DETECTOR_TYPE(MID_DET_APD), .LINE_MOD(MID_LINE_RZ),
    .SIGNAL_CODING(MID_CODE_QAM64), .POWER_DRAW(T_DRAW), .CASE_TEMP_MIN(T_TMIN), .COMPANY_ID(T_CID),
    .HW_VER_MINOR(T_HWMIN), .FW_VER_MAJOR(T_FWMAJ), .TX_AVG_POWER(T_OFF), .MODULE_MON_CAPS(T_MONC),
    .LANE_MON_CAPS(T_LCAP), .OPT_FEATURES_1(T_OPT1), .POWER_UP_MS(T_PUP), .POWER_DOWN_MS(T_PDN), .TX_OFF_US(T_TOFF),
    .HOST_IFACE(MID_HOST_SFI52), .INTEGRATED_SINK(T_ON), .DECISION_ADJUST(T_ON)
  ) dut (.core_clk_i(core_clk), .arst_n_i(arst_n), .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_ack_o(ack), .reg_hit_o(hit), .table_sum_o(sum));
  mid_host_model host (.core_clk_i(core_clk), .reg_rdata_i(rdata), .reg_ack_i(ack), .reg_hit_i(hit),
    .reg_addr_o(addr), .reg_rd_o(rd), .reg_wr_o(wr), .reg_wdata_o(wdata));
  function automatic logic [7:0] tl(int t);
    int v;
    v = (t + 999) / 1000;
    return (v < 1) ? 8'h01 : (v > 255) ? 8'hff : 8'(v);
  endfunction
  task automatic put(int base, logic [127:0] v, int len);
    for (int i = 0; i < len; i++) rom[base + i] = v[8 * (len - 1 - i) +: 8];
  endtask
  task automatic go(logic [ADDR_W-1:0] a, logic r, logic w);
    logic hit_e;
    hit_e = (a >= TABLE_FIRST_ADDR) && (a <= TABLE_LAST_ADDR);
    if (r) last = hit_e ? {8'h00, rom[a]} : 16'h0000;
    eq.push_back(last);
    hx.push_back(int'(hit_e));
    host.strobe(a, r, w, 16'($urandom));
  endtask
  task automatic drain(string name);
    logic [DATA_W-1:0] d, e;
    logic              h;
    int                x;
    host.idle();
    repeat (3) @(posedge core_clk);
    `CHK(host.rq.size(), eq.size())
    while (eq.size() > 0 && host.rq.size() > 0) begin
      d = host.rq.pop_front();
      h = host.hq.pop_front();
      e = eq.pop_front();
      x = hx.pop_front();
      `CHK(d, e)
      if (x >= 0) `CHK(h, x[0])
    end
    eq.delete();
    hx.delete();
    $display("test %s done", name);
  endtask
  task automatic do_reset();
    arst_n <= 1'b0;
    host.idle();
    repeat (2) @(posedge core_clk);
    `CHK(rdata, 16'h0000)
    `CHK(ack, 1'b0)
    `CHK(sum, 8'h00)
    arst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    host.rq.delete();
    host.hq.delete();
    eq.delete();
    hx.delete();
    last = 16'h0000;
    `CHK(sum, 8'(tsum))
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    close_out();
  end
  initial begin
    seed = $urandom(6);
    foreach (rom[i]) rom[i] = 8'h00;
    rom[16'h800a] = {2'b11, 1'b1, 1'b0, 4'h0};
    rom[16'h800b] = 8'hc8;
    rom[16'h800d] = 8'h0a;
    rom[16'h8010] = 8'h1f;
    rom[16'h8011] = 8'h13;
    put(16'h8012, 32'hbeef1234, 4);
    put(16'h8016, 16'h0a5c, 2);
    rom[16'h8018] = {4'h4, 4'h2};
    rom[16'h8019] = {4'ha, 2'b10, 2'b00};
    rom[16'h801a] = {2'b10, 4'hc, 2'b00};
    rom[16'h801d] = 8'h44;
    rom[16'h801f] = 8'h46;
    rom[16'h8020] = 8'hd8;
    put(16'h8021, "GENERIC MAKER   ", 16);
    put(16'h8031, 24'habcdef, 3);
    put(16'h8034, "PART0000        ", 16);
    put(16'h8044, "SERIAL0000      ", 16);
    put(16'h8054, "20000101", 8);
    put(16'h805c, "00", 2);
    put(16'h805e, "0000000000", 10);
    put(16'h8068, 16'h0a0a, 2);
    put(16'h806a, 32'h01070300, 4);
    rom[16'h806e] = {4'h0, 1'b1, 1'b0, 2'b00};
    rom[16'h806f] = 8'hf7;
    rom[16'h8070] = 8'h0b;
    rom[16'h8071] = 8'h5a;
    rom[16'h8072] = tl(1001);
    rom[16'h8073] = tl(1);
    rom[16'h8074] = 8'h03;
    rom[16'h8075] = 8'h01;
    rom[16'h8076] = tl(999);
    rom[16'h8077] = tl(2000);
    rom[16'h8078] = {3'h0, 1'b1, 4'h0};
    tsum = 0;
    foreach (rom[i]) tsum += rom[i];
    do_reset();
    for (int a = 16'h8009; a <= 16'h8079; a++) go(16'(a), 1'b1, 1'b0);
    drain("sweep");
    for (int i = 0; i < 8; i++) begin
      addr_w = 16'(TABLE_FIRST_ADDR + $urandom_range(0, 110));
      go(addr_w, 1'b0, 1'b1);
      go(addr_w, 1'b1, 1'b0);
      go(addr_w, 1'b0, 1'b1);
    end
    go(16'h8078, 1'b1, 1'b1);
    go(16'h0000, 1'b0, 1'b1);
    drain("write");
    for (int i = 0; i < 40; i++) begin
      go(16'($urandom_range(16'h7ff0, 16'h8090)), 1'b1, 1'b0);
      if ($urandom_range(0, 1) == 1) host.idle();
    end
    drain("random");
    go(16'h800a, 1'b1, 1'b0);
    do_reset();
    go(16'h8021, 1'b1, 1'b0);
    drain("reset");
    close_out();
  end
endmodule // tb_mid_capability_rom
`default_nettype wire
